// [design/host_decode_regs.vh]
// Functional notes
// - Three-bit address selects eight byte registers, codes 111 down to 000.
// - Two chip selects each open a private register copy for four channels.
// - Serial port sees the same map and functions as the parallel port.
// - Auto-increment bit 7 advances the internal address after each internal access.
// - Access control bits 1-0 pick the channel, forming internal address bits 9-8.
// - Bit 6 broadcast flag selects how instruction bits 5-2 are read.
// - Without broadcast, bits 4-2 must match identity pins to take the access.
// - Broadcast 0000 all channels, 0001 channels 0-2, 0010 channels 1-3.
// - Broadcast 0100 and 1000 take every chip regardless of identity pins.
// - Broadcast 1100 needs identity bit 0 low, 1110 needs it high.
// - Whole-chip broadcast instructions use channel-select bits for one channel.
// - Multi-channel instructions ignore the channel-select bits.
// - With port-register access set, channel-select bits are not decoded.
// - Trigger enable register: test toggle, first-only, hop, start, four enables.
// - Power-down register: map select bit 5, sleep bits 3-0, others kept low.
// - Data registers carry a 20-bit word: nibble, middle byte, low byte.
// - Writing the low data register launches the internal write.
// - Reading the low data register launches the internal read.
// - Port-register access bit redirects the internal address to the port map.
`ifndef HOST_DECODE_REGS_VH
`define HOST_DECODE_REGS_VH
`define ADDR_DATA_LOW 3'h0
`define ADDR_DATA_MID 3'h1
`define ADDR_DATA_UPPER 3'h2
`define ADDR_POWER_DOWN 3'h3
`define ADDR_TRIG_ENABLE 3'h4
`define ADDR_SOFT_TRIG 3'h5
`define ADDR_INT_ADDR 3'h6
`define ADDR_ROUTING 3'h7
`define RT_AUTO_INC 7
`define RT_BROADCAST 6
`define RT_INSTR_HI 5
`define RT_INSTR_LO 2
`define PD_PORT_MAP 5
`define PD_WRITE_MASK 8'h2F
`define UPPER_MASK 8'h0F
`define INSTR_ALL 4'h0
`define INSTR_CH012 4'h1
`define INSTR_CH123 4'h2
`define INSTR_CHIPS_A 4'h4
`define INSTR_CHIPS_B 4'h8
`define INSTR_ID_EVEN 4'hC
`define INSTR_ID_ODD 4'hE
`define CHMASK_ALL 4'hF
`define CHMASK_012 4'h7
`define CHMASK_123 4'hE
`define ZERO_BYTE 8'h00
`endif

// [design/routing_decode.v]
`timescale 1ns/1ns
`include "host_decode_regs.vh"
module routing_decode (
    // Routing control and pins
    input wire [7:0] routing_i,
    input wire [2:0] chip_identity_pins_i,
    input wire port_map_i,
    // Result
    output reg granted_o,
    output reg [3:0] channel_mask_o
);
    reg [3:0] instr;
    reg [3:0] one_hot;

    always @* begin
        instr = routing_i[`RT_INSTR_HI:`RT_INSTR_LO];
        one_hot = 4'h1 << routing_i[1:0];
        granted_o = 1'b0;
        channel_mask_o = one_hot;
        if (!routing_i[`RT_BROADCAST]) begin
            granted_o = (instr[2:0] == chip_identity_pins_i);
        end else begin
            case (instr)
                `INSTR_ALL: begin
                    granted_o = 1'b1;
                    channel_mask_o = `CHMASK_ALL;
                end
                `INSTR_CH012: begin
                    granted_o = 1'b1;
                    channel_mask_o = `CHMASK_012;
                end
                `INSTR_CH123: begin
                    granted_o = 1'b1;
                    channel_mask_o = `CHMASK_123;
                end
                `INSTR_CHIPS_A, `INSTR_CHIPS_B: begin
                    granted_o = 1'b1;
                end
                `INSTR_ID_EVEN: begin
                    granted_o = ~chip_identity_pins_i[0];
                end
                `INSTR_ID_ODD: begin
                    granted_o = chip_identity_pins_i[0];
                end
                default: begin
                    granted_o = 1'b0;
                end
            endcase
        end
        // Port registers are shared, so the channel bits carry no meaning
        if (port_map_i) begin
            channel_mask_o = `CHMASK_ALL;
        end
    end
endmodule // routing_decode

// [design/host_external_register_decode.v]
`timescale 1ns/1ns
`include "host_decode_regs.vh"
module host_external_register_decode #(
    parameter DATA_W = 20
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire reset_i,
    // Host port, shared by parallel and serial front ends
    input wire lower_half_select_i,
    input wire upper_half_select_i,
    input wire [2:0] addr_i,
    input wire write_i,
    input wire read_i,
    input wire [7:0] wdata_i,
    output reg [7:0] rdata_o,
    // Identity pins per half
    input wire [2:0] chip_identity_pins_lo_i,
    input wire [2:0] chip_identity_pins_hi_i,
    // Internal access port
    output reg int_write_o,
    output reg int_read_o,
    output reg int_half_o,
    output reg int_port_map_o,
    output reg [3:0] int_channel_mask_o,
    output reg [9:0] int_addr_o,
    output reg [DATA_W-1:0] int_wdata_o,
    input wire [DATA_W-1:0] int_rdata_i,
    input wire int_rdata_valid_i,
    // Control outputs, lower half then upper half
    output wire [7:0] external_trigger_enable_lo_o,
    output wire [7:0] external_trigger_enable_hi_o,
    output wire [7:0] software_trigger_control_lo_o,
    output wire [7:0] software_trigger_control_hi_o,
    output reg soft_trigger_pulse_lo_o,
    output reg soft_trigger_pulse_hi_o,
    output wire [3:0] channel_sleep_lo_o,
    output wire [3:0] channel_sleep_hi_o
);
    // One copy of the register space per chip select
    reg [7:0] routing [0:1];
    reg [7:0] int_addr_low [0:1];
    reg [7:0] trig_en [0:1];
    reg [7:0] soft_trig [0:1];
    reg [7:0] power_down [0:1];
    reg [7:0] data_upper [0:1];
    reg [7:0] data_mid [0:1];
    reg [7:0] data_low [0:1];

    wire sel_any;
    wire half;
    wire [2:0] id_pins;
    wire granted;
    wire [3:0] ch_mask;
    wire do_write;
    wire do_read;
    reg read_pending;
    reg pending_half;
    integer i;

    // Lower half wins if both selects are asserted
    assign sel_any = lower_half_select_i | upper_half_select_i;
    assign half = ~lower_half_select_i & upper_half_select_i;
    assign id_pins = half ? chip_identity_pins_hi_i : chip_identity_pins_lo_i;
    assign do_write = sel_any & write_i;
    assign do_read = sel_any & read_i & ~write_i;

    assign external_trigger_enable_lo_o = trig_en[0];
    assign external_trigger_enable_hi_o = trig_en[1];
    assign software_trigger_control_lo_o = soft_trig[0];
    assign software_trigger_control_hi_o = soft_trig[1];
    assign channel_sleep_lo_o = power_down[0][3:0];
    assign channel_sleep_hi_o = power_down[1][3:0];

    routing_decode u_routing_decode (
        .routing_i(routing[half]),
        .chip_identity_pins_i(id_pins),
        .port_map_i(power_down[half][`PD_PORT_MAP]),
        .granted_o(granted),
        .channel_mask_o(ch_mask)
    );

    // Register read mux, identical for both front ends
    function [7:0] read_mux;
        input [2:0] a;
        input h;
        begin
            case (a)
                `ADDR_ROUTING: read_mux = routing[h];
                `ADDR_INT_ADDR: read_mux = int_addr_low[h];
                `ADDR_DATA_UPPER: read_mux = data_upper[h] & `UPPER_MASK;
                `ADDR_DATA_MID: read_mux = data_mid[h];
                `ADDR_DATA_LOW: read_mux = data_low[h];
                default: read_mux = `ZERO_BYTE; // Write-only registers
            endcase
        end
    endfunction

    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (i = 0; i < 2; i = i + 1) begin
                routing[i] <= `ZERO_BYTE;
                int_addr_low[i] <= `ZERO_BYTE;
                trig_en[i] <= `ZERO_BYTE;
                soft_trig[i] <= `ZERO_BYTE;
                power_down[i] <= `ZERO_BYTE;
                data_upper[i] <= `ZERO_BYTE;
                data_mid[i] <= `ZERO_BYTE;
                data_low[i] <= `ZERO_BYTE;
            end
            rdata_o <= `ZERO_BYTE;
            int_write_o <= 1'b0;
            int_read_o <= 1'b0;
            int_half_o <= 1'b0;
            int_port_map_o <= 1'b0;
            int_channel_mask_o <= 4'h0;
            int_addr_o <= 10'h000;
            int_wdata_o <= {DATA_W{1'b0}};
            soft_trigger_pulse_lo_o <= 1'b0;
            soft_trigger_pulse_hi_o <= 1'b0;
            read_pending <= 1'b0;
            pending_half <= 1'b0;
        end else begin
            int_write_o <= 1'b0;
            int_read_o <= 1'b0;
            soft_trigger_pulse_lo_o <= 1'b0;
            soft_trigger_pulse_hi_o <= 1'b0;
            // Refill comes first so a read launched in the same cycle keeps its pending flag
            // Broadcast readback is undefined; data is captured anyway
            if (read_pending && int_rdata_valid_i) begin
                read_pending <= 1'b0;
                data_low[pending_half] <= int_rdata_i[7:0];
                data_mid[pending_half] <= int_rdata_i[15:8];
                data_upper[pending_half] <= {4'h0, int_rdata_i[19:16]};
            end
            if (do_write) begin
                case (addr_i)
                    `ADDR_ROUTING: routing[half] <= wdata_i;
                    `ADDR_INT_ADDR: int_addr_low[half] <= wdata_i;
                    `ADDR_SOFT_TRIG: begin
                        soft_trig[half] <= wdata_i;
                        soft_trigger_pulse_lo_o <= ~half;
                        soft_trigger_pulse_hi_o <= half;
                    end
                    `ADDR_TRIG_ENABLE: trig_en[half] <= wdata_i;
                    `ADDR_POWER_DOWN: power_down[half] <= wdata_i & `PD_WRITE_MASK;
                    `ADDR_DATA_UPPER: data_upper[half] <= wdata_i & `UPPER_MASK;
                    `ADDR_DATA_MID: data_mid[half] <= wdata_i;
                    `ADDR_DATA_LOW: begin
                        data_low[half] <= wdata_i;
                        // Launch write of the assembled word
                        int_write_o <= granted;
                        int_half_o <= half;
                        int_port_map_o <= power_down[half][`PD_PORT_MAP];
                        int_channel_mask_o <= ch_mask;
                        int_addr_o <= {routing[half][1:0], int_addr_low[half]};
                        int_wdata_o <= {data_upper[half][3:0], data_mid[half],
                            wdata_i};
                        if (granted && routing[half][`RT_AUTO_INC]) begin
                            // Plain 8-bit add wraps, channel bits untouched
                            int_addr_low[half] <= int_addr_low[half] + 8'h01;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (do_read) begin
                rdata_o <= read_mux(addr_i, half);
                if (addr_i == `ADDR_DATA_LOW) begin
                    // Launch internal read; returned word refills data registers
                    int_read_o <= granted;
                    read_pending <= granted;
                    pending_half <= half;
                    int_half_o <= half;
                    int_port_map_o <= power_down[half][`PD_PORT_MAP];
                    int_channel_mask_o <= ch_mask;
                    int_addr_o <= {routing[half][1:0], int_addr_low[half]};
                    if (granted && routing[half][`RT_AUTO_INC]) begin
                        int_addr_low[half] <= int_addr_low[half] + 8'h01;
                    end
                end
            end
        end
    end
endmodule // host_external_register_decode

// [bench/host_decode_properties.sv]
`timescale 1ns/1ns
module host_decode_checker #(
    parameter DATA_W = 20
) (
    // Clock, reset and host side
    input wire sys_clk_i,
    input wire reset_i,
    input wire lower_half_select_i,
    input wire upper_half_select_i,
    input wire [2:0] addr_i,
    input wire write_i,
    input wire read_i,
    input wire [7:0] wdata_i,
    // Internal side and controls
    input wire int_write_o,
    input wire int_read_o,
    input wire int_half_o,
    input wire int_port_map_o,
    input wire [3:0] int_channel_mask_o,
    input wire [DATA_W-1:0] int_wdata_o,
    input wire [7:0] external_trigger_enable_lo_o,
    input wire soft_trigger_pulse_lo_o,
    input wire [3:0] channel_sleep_lo_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    wire sel = lower_half_select_i | upper_half_select_i;
    wire wr_lo = lower_half_select_i & write_i;
    a_write_cause: assert property (int_write_o |-> $past(sel && write_i && addr_i == 3'h0))
        else $error("internal write without low data write");
    a_read_cause: assert property (int_read_o |-> $past(sel && read_i && !write_i && addr_i == 3'h0))
        else $error("internal read without low data read");
    a_soft_pulse: assert property (wr_lo && addr_i == 3'h5 |=> soft_trigger_pulse_lo_o)
        else $error("soft trigger pulse missing");
    a_sleep_bits: assert property (wr_lo && addr_i == 3'h3 |=> channel_sleep_lo_o == $past(wdata_i[3:0]))
        else $error("sleep bits wrong");
    a_trig_reg: assert property (wr_lo && addr_i == 3'h4 |=> external_trigger_enable_lo_o == $past(wdata_i))
        else $error("trigger enable wrong");
    a_word_low: assert property (int_write_o |-> int_wdata_o[7:0] == $past(wdata_i))
        else $error("low byte of word wrong");
    a_half_pick: assert property (int_write_o || int_read_o |-> int_half_o == !$past(lower_half_select_i))
        else $error("half select wrong");
    a_port_mask: assert property (int_write_o && int_port_map_o |-> int_channel_mask_o == 4'hF)
        else $error("port map mask wrong");
    c_write: cover property (int_write_o);
    c_read: cover property (int_read_o);
    c_port: cover property (int_write_o && int_port_map_o);
endmodule // host_decode_checker
bind host_external_register_decode host_decode_checker #(.DATA_W(DATA_W)) u_chk (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .lower_half_select_i(lower_half_select_i),
    .upper_half_select_i(upper_half_select_i), .addr_i(addr_i), .write_i(write_i),
    .read_i(read_i), .wdata_i(wdata_i), .int_write_o(int_write_o), .int_read_o(int_read_o),
    .int_half_o(int_half_o), .int_port_map_o(int_port_map_o),
    .int_channel_mask_o(int_channel_mask_o), .int_wdata_o(int_wdata_o),
    .external_trigger_enable_lo_o(external_trigger_enable_lo_o),
    .soft_trigger_pulse_lo_o(soft_trigger_pulse_lo_o), .channel_sleep_lo_o(channel_sleep_lo_o));

// [bench/int_memory_model.sv]
`timescale 1ns/1ns
module int_memory_model (
    input wire clk_i,
    input wire reset_i,
    input wire write_i,
    input wire read_i,
    input wire [19:0] wdata_i,
    output reg [19:0] rdata_o,
    output reg valid_o
);
    reg [19:0] mem;
    reg [1:0] wait_cnt;
    reg busy;
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mem <= 20'h00000;
            rdata_o <= 20'hA5A5A;
            valid_o <= 1'b0;
            busy <= 1'b0;
            wait_cnt <= 2'h0;
        end else begin
            valid_o <= 1'b0;
            // Data toggles outside the answer so stale values never pass
            rdata_o <= ~rdata_o;
            if (write_i)
                mem <= wdata_i;
            if (read_i) begin
                busy <= 1'b1;
                wait_cnt <= 2'h2;
            end else if (busy && wait_cnt == 2'h0) begin
                valid_o <= 1'b1;
                rdata_o <= mem;
                busy <= 1'b0;
            end else if (busy)
                wait_cnt <= wait_cnt - 2'h1;
        end
    end
endmodule // int_memory_model

// [bench/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
    reg sys_clk_i = 0, reset_i = 1, lo = 0, hi = 0, wr = 0, rd = 0;
    reg [2:0] addr = 3'h0, pins_lo = 3'h5, pins_hi = 3'h2;
    reg [7:0] wd = 8'h00;
    wire [7:0] rdata, trig_lo, trig_hi, soft_lo, soft_hi;
    wire iw, ir, ihalf, ipm, ivalid, sp_lo, sp_hi;
    wire [3:0] mask, sl_lo, sl_hi;
    wire [9:0] iaddr;
    wire [19:0] iwd, ird;
    integer n_fail = 0, num_checks = 0, cyc = 0, i, t;
    reg [3:0] m;
    always #4 sys_clk_i = ~sys_clk_i;
    host_external_register_decode dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .lower_half_select_i(lo), .upper_half_select_i(hi), .addr_i(addr), .write_i(wr),
        .read_i(rd), .wdata_i(wd), .rdata_o(rdata), .chip_identity_pins_lo_i(pins_lo),
        .chip_identity_pins_hi_i(pins_hi), .int_write_o(iw), .int_read_o(ir),
        .int_half_o(ihalf), .int_port_map_o(ipm), .int_channel_mask_o(mask),
        .int_addr_o(iaddr), .int_wdata_o(iwd), .int_rdata_i(ird), .int_rdata_valid_i(ivalid),
        .external_trigger_enable_lo_o(trig_lo), .external_trigger_enable_hi_o(trig_hi),
        .software_trigger_control_lo_o(soft_lo), .software_trigger_control_hi_o(soft_hi),
        .soft_trigger_pulse_lo_o(sp_lo), .soft_trigger_pulse_hi_o(sp_hi),
        .channel_sleep_lo_o(sl_lo), .channel_sleep_hi_o(sl_hi));
    int_memory_model u_mem (.clk_i(sys_clk_i), .reset_i(reset_i), .write_i(iw),
        .read_i(ir), .wdata_i(iwd), .rdata_o(ird), .valid_o(ivalid));
    task acc(input s, input w, input [2:0] a, input [7:0] d);
        @(posedge sys_clk_i);
        lo <= !s; hi <= s; addr <= a; wr <= w; rd <= !w; wd <= d;
        @(posedge sys_clk_i);
        lo <= 0; hi <= 0; wr <= 0; rd <= 0;
        #1;
    endtask
    task chk(input [31:0] g, input [31:0] e);
        num_checks = num_checks + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wrap_up;
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Ceiling well above the hundred or so cycles the sequence needs
    always @(posedge sys_clk_i) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_fail = n_fail + 1;
            wrap_up;
        end
    end
    initial begin
        repeat (3) @(posedge sys_clk_i);
        reset_i <= 0;
        acc(0, 0, 3'h7, 0); chk(rdata, 8'h00);
        acc(0, 1, 3'h7, 8'h96); acc(0, 1, 3'h6, 8'hFF);
        acc(0, 1, 3'h2, 8'hA5); acc(0, 1, 3'h1, 8'h3C); acc(0, 1, 3'h0, 8'h7E);
        chk(iw, 1); chk(iaddr, 10'h2FF); chk(mask, 4'h4);
        chk(iwd, 20'h53C7E);
        acc(0, 0, 3'h6, 0); chk(rdata, 8'h00);
        acc(0, 0, 3'h2, 0); chk(rdata, 8'h05);
        acc(0, 0, 3'h7, 0); chk(rdata, 8'h96);
        acc(0, 1, 3'h7, 8'h88); acc(0, 1, 3'h0, 8'h11); chk(iw, 0);
        acc(0, 0, 3'h6, 0); chk(rdata, 8'h00);
        // Codes 0,1,2,4,8,C,E and undefined 3 with channel 1; identity bit 0 is high
        for (i = 0; i < 8; i = i + 1) begin
            acc(0, 1, 3'h7, {2'b01, 4'(32'h01248CE3 >> (28 - 4 * i)), 2'b01});
            acc(0, 1, 3'h0, 8'h00);
            m = 4'(32'hF7E22020 >> (28 - 4 * i));
            chk(iw, m != 0);
            if (m != 0)
                chk(mask, m);
        end
        acc(0, 1, 3'h3, 8'h2F); chk(sl_lo, 4'hF); chk(sl_hi, 4'h0);
        acc(0, 1, 3'h7, 8'h15); acc(0, 1, 3'h0, 8'h00);
        chk(ipm, 1); chk(mask, 4'hF);
        acc(0, 1, 3'h3, 8'h00); acc(0, 1, 3'h4, 8'h81); acc(0, 1, 3'h5, 8'h02);
        chk(trig_lo, 8'h81); chk(soft_lo, 8'h02);
        acc(0, 1, 3'h2, 8'h0B); acc(0, 1, 3'h1, 8'hCD); acc(0, 1, 3'h0, 8'hEF);
        // Upper and mid overwritten, so only the refill can bring the stored word back
        acc(0, 1, 3'h2, 8'h03); acc(0, 1, 3'h1, 8'h44); acc(0, 1, 3'h7, 8'h95);
        acc(0, 0, 3'h0, 0); chk(ir, 1); chk(rdata, 8'hEF);
        t = 0;
        while (ivalid !== 1'b1 && t < 20) begin
            @(posedge sys_clk_i);
            #1;
            t = t + 1;
        end
        chk(ivalid, 1);
        acc(0, 0, 3'h6, 0); chk(rdata, 8'h01);
        acc(0, 0, 3'h1, 0); chk(rdata, 8'hCD);
        acc(0, 0, 3'h2, 0); chk(rdata, 8'h0B);
        acc(0, 0, 3'h0, 0); chk(rdata, 8'hEF);
        acc(1, 1, 3'h4, 8'h3C); chk(trig_hi, 8'h3C); chk(trig_lo, 8'h81);
        acc(1, 1, 3'h5, 8'h01); chk(sp_hi, 1); chk(soft_hi, 8'h01);
        acc(1, 0, 3'h4, 0); chk(rdata, 8'h00);
        acc(1, 1, 3'h7, 8'h08); acc(1, 1, 3'h0, 8'h00); chk(ihalf, 1);
        wrap_up;
    end
endmodule // tb_top
